// *** design/ptc_chan_service.sv ***
// Notes on behaviour
// RULE_01: Channels 12,13 take serial port zero tx/rx; 14,15 port one.
// RULE_02: Each channel owns its parameter set: counts, size, layout.
// RULE_03: With frame sync select clear, one event moves one element.
// RULE_04: Update mode 00b keeps the address fixed between elements.
// RULE_05: Update mode 01b steps the address by element size.
// RULE_06: Mode 11b adds element index in frame, frame index at boundary.
// RULE_07: Element size code 10b means 8-bit elements.
// RULE_08: Frame sync set moves one whole array per event.
// RULE_09: Software sets array count to arrays minus one.
// RULE_10: 2-D array index is the distance between array start addresses.
// RULE_11: Exhausted linked channel copies the link set and keeps running.
// RULE_12: Element count reloads from its reload value on reaching zero.
// RULE_13: High priority channels issue requests on queue one.
// RULE_14: Ping-pong: each completion loads the other set via link.
// RULE_15: Completion interrupt enable raises interrupt with report code.
// RULE_16: Completion sets pending bit at report code until cleared.
// RULE_17: Serial port raises one event per element moved.
// RULE_18: Channel 4 is paced by external interrupt line four.
// RULE_19: Transmit channel steps source while destination stays fixed.
// RULE_20: Events count only when enabled, unless triggered by the CPU.
// RULE_21: A link reload completes before the next event is serviced.
`timescale 1ns/1ps
`default_nettype none
`include "ptc_map.svh"

module ptc_chan_service (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Peripheral sync events, asynchronous pins
  input wire logic transmit_event_zero_in,
  input wire logic receive_event_zero_in,
  input wire logic transmit_event_one_in,
  input wire logic receive_event_one_in,
  input wire logic external_irq_four_in,
  input wire logic [15:0] other_evt_in,
  // CPU event control, same clock
  input wire logic [15:0] event_enable_register_in,
  input wire logic [15:0] cpu_evt_set_in,
  // Parameter set loading
  input wire logic cfg_wr_in,
  input wire logic [5:0] cfg_addr_in,
  input var ptc_pkg::ptc_set_t cfg_data_in,
  output logic cfg_busy_out,
  // Completion reporting
  input wire logic [15:0] pend_clr_in,
  output logic [15:0] channel_pending_register_out,
  output logic completion_irq_out,
  output logic [3:0] completion_code_out,
  // Transfer requests
  output logic tr_valid_out,
  output ptc_pkg::ptc_req_t tr_out,
  input wire logic tr_ready_in
);

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  ptc_pkg::ptc_core_t q;
  ptc_pkg::ptc_core_t d;
  ptc_pkg::ptc_set_t rd_data;
  ptc_pkg::ptc_set_t mem_wdata;
  logic mem_we;
  logic [5:0] mem_waddr;
  logic [5:0] mem_raddr;
  logic [31:0] src_next;
  logic [31:0] dst_next;
  logic [1:0] shift;
  logic last_elem;
  logic [15:0] raw_evt;
  logic [15:0] edges;
  logic [15:0] evt_clr;
  logic [15:0] pend_set;
  logic [3:0] pick;
  logic pick_any;
  logic issue;
  logic burst_end;
  logic done;

  // Channel n owns set n; sets 16 and up only serve as link targets
  ptc_set_mem u_mem (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .raddr_in(mem_raddr),
    .rdata_out(rd_data)
  );

  // ----------------------------------------------------------------
  // Address updates, one step unit per side
  // ----------------------------------------------------------------
  // Same unit serves both sides, so a transmit set simply programs
  // the source to index and the destination to hold
  ptc_addr_step u_src_step (
    .addr_in(q.set.src),
    .mode_in(q.set.opt.source_update_mode),
    .shift_in(shift),
    .two_dim_in(q.set.opt.src_two_dim),
    .last_in(last_elem),
    .elem_idx_in(q.set.elem_idx),
    .frame_idx_in(q.set.frame_idx),
    .reload_in(q.set.elem_reload),
    .addr_out(src_next)
  ); // RULE_19

  // Destination side, the moving address of the receive channels
  ptc_addr_step u_dst_step (
    .addr_in(q.set.dst),
    .mode_in(q.set.opt.dest_update_mode),
    .shift_in(shift),
    .two_dim_in(q.set.opt.dst_two_dim),
    .last_in(last_elem),
    .elem_idx_in(q.set.elem_idx),
    .frame_idx_in(q.set.frame_idx),
    .reload_in(q.set.elem_reload),
    .addr_out(dst_next)
  );

  // ----------------------------------------------------------------
  // Event mapping and selection
  // ----------------------------------------------------------------
  // Fixed wiring of peripheral events onto their dedicated channels
  always_comb begin
    raw_evt = other_evt_in;
    raw_evt[`PTC_CH_SP0_TX] = transmit_event_zero_in; // RULE_01
    raw_evt[`PTC_CH_SP0_RX] = receive_event_zero_in; // RULE_01
    raw_evt[`PTC_CH_SP1_TX] = transmit_event_one_in; // RULE_01
    raw_evt[`PTC_CH_SP1_RX] = receive_event_one_in; // RULE_01
    raw_evt[`PTC_CH_EXT4] = external_irq_four_in; // RULE_18
  end

  // Rising edges after the synchroniser; disabled events are dropped
  assign edges = q.sync2 & ~q.sync3 & event_enable_register_in; // RULE_20

  // Lowest numbered waiting channel wins
  // Fixed priority could starve a high channel under a flood of low
  // ones; accepted because every service is short and events latch
  always_comb begin
    pick = 4'h0;
    pick_any = 1'b0;
    for (int i = `PTC_NUM_CH - 1; i >= 0; i--) begin
      if (q.evt[i]) begin
        pick = 4'(i);
        pick_any = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Element bookkeeping
  // ----------------------------------------------------------------
  always_comb begin
    unique case (q.set.opt.element_size_field)
      `PTC_ESZ_16: shift = `PTC_SH_16;
      `PTC_ESZ_8: shift = `PTC_SH_8; // RULE_07
      default: shift = `PTC_SH_32;
    endcase
  end

  // Count is one at the last element of an array; the array
  // count holds arrays minus one, so zero there ends the block
  assign last_elem = (q.set.elem_cnt == 16'h0001);
  assign done = last_elem && (q.set.frame_cnt == 16'h0000); // RULE_09
  assign burst_end = q.set.opt.frame_sync_select ? last_elem : 1'b1;
  // A new request may leave on the edge that hands the old one over,
  // so a ready consumer sees one element per clock
  assign issue = (q.st == ptc_pkg::S_XFER) &&
                 (!q.req_valid || tr_ready_in);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    evt_clr = 16'h0000;
    pend_set = 16'h0000;
    mem_we = 1'b0;
    mem_waddr = cfg_addr_in;
    mem_wdata = cfg_data_in;
    mem_raddr = {2'b00, q.ch};
    d.irq = 1'b0;

    // Two-flop synchroniser, then one more flop for the edge
    d.sync1 = raw_evt;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;

    // Request leaves when the consumer takes it
    if (q.req_valid && tr_ready_in) begin
      d.req_valid = 1'b0;
    end

    unique case (q.st)
      ptc_pkg::S_IDLE: begin
        // Loading is only taken while idle, so it never races writeback
        if (cfg_wr_in) begin
          mem_we = 1'b1;
        end
        if (pick_any) begin
          evt_clr[pick] = 1'b1;
          d.ch = pick;
          d.st = ptc_pkg::S_RD;
        end
      end
      ptc_pkg::S_RD: begin
        d.st = ptc_pkg::S_LOAD;
      end
      ptc_pkg::S_LOAD: begin
        d.set = rd_data; // RULE_02
        d.st = ptc_pkg::S_XFER;
      end
      ptc_pkg::S_XFER: begin
        if (issue) begin
          d.req_valid = 1'b1;
          d.req.src = q.set.src;
          d.req.dst = q.set.dst;
          d.req.element_size_field = q.set.opt.element_size_field;
          d.req.channel = q.ch;
          d.req.queue = q.set.opt.hi_pri ? `PTC_Q_HI : `PTC_Q_LO; // RULE_13
          d.set.src = src_next;
          d.set.dst = dst_next;
          if (last_elem) begin
            d.set.elem_cnt = q.set.elem_reload; // RULE_12
            d.set.frame_cnt = q.set.frame_cnt - 16'h0001;
          end else begin
            d.set.elem_cnt = q.set.elem_cnt - 16'h0001;
          end
          // One element per event, or a whole array per event
          if (burst_end) begin // RULE_03 RULE_08
            d.st = ptc_pkg::S_WB;
          end
          if (done) begin
            // Pending bit and pulse are set on the issuing edge
            if (q.set.opt.completion_interrupt_enable) begin
              pend_set[q.set.opt.report_code] = 1'b1; // RULE_16
              d.irq = 1'b1; // RULE_15
              d.irq_code = q.set.opt.report_code; // RULE_15
            end
            if (q.set.opt.link_enable) begin
              d.st = ptc_pkg::S_LRD; // RULE_11
            end
          end
        end
      end
      ptc_pkg::S_LRD: begin
        // Read the set that the link field points at
        mem_raddr = q.set.link_addr; // RULE_14
        d.st = ptc_pkg::S_LLD;
      end
      ptc_pkg::S_LLD: begin
        d.set = rd_data; // RULE_11 RULE_14
        d.st = ptc_pkg::S_WB;
      end
      ptc_pkg::S_WB: begin
        // Events wait in the latch until the reload is stored
        mem_we = 1'b1; // RULE_21
        mem_waddr = {2'b00, q.ch};
        mem_wdata = q.set;
        d.st = ptc_pkg::S_IDLE;
      end
      default: begin
        d.st = ptc_pkg::S_IDLE;
      end
    endcase

    // A new event or completion wins over a clear in the same cycle
    d.evt = (q.evt & ~evt_clr) | edges | cpu_evt_set_in; // RULE_20
    d.pend = (q.pend & ~pend_clr_in) | pend_set; // RULE_16
    // Busy follows the next state, so loading closes right after a pick
    d.busy = (d.st != ptc_pkg::S_IDLE);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      // Latches start empty, so no stale edge is served after reset
      q <= '0;
      q.st <= ptc_pkg::S_IDLE;
      q.evt <= `PTC_EVT_RST;
      q.pend <= `PTC_PEND_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  // Each output is a field of q, so none passes through logic
  assign cfg_busy_out = q.busy;
  assign channel_pending_register_out = q.pend;
  assign completion_irq_out = q.irq;
  assign completion_code_out = q.irq_code;
  assign tr_valid_out = q.req_valid;
  assign tr_out = q.req;

endmodule : ptc_chan_service

`default_nettype wire

// *** design/ptc_map.svh ***
`ifndef PTC_MAP_SVH
`define PTC_MAP_SVH

// ----------------------------------------------------------------
// Channel map
// ----------------------------------------------------------------
`define PTC_NUM_CH 16
`define PTC_SET_DEPTH 64
`define PTC_CH_EXT4 4'h4
`define PTC_CH_SP0_TX 4'hC
`define PTC_CH_SP0_RX 4'hD
`define PTC_CH_SP1_TX 4'hE
`define PTC_CH_SP1_RX 4'hF

// ----------------------------------------------------------------
// Address update modes
// ----------------------------------------------------------------
`define PTC_UPD_HOLD 2'b00
`define PTC_UPD_INC 2'b01
`define PTC_UPD_DEC 2'b10
`define PTC_UPD_IDX 2'b11

// ----------------------------------------------------------------
// Element size codes and their byte shifts
// ----------------------------------------------------------------
`define PTC_ESZ_32 2'b00
`define PTC_ESZ_16 2'b01
`define PTC_ESZ_8 2'b10
`define PTC_SH_32 2'd2
`define PTC_SH_16 2'd1
`define PTC_SH_8 2'd0

// ----------------------------------------------------------------
// Queues and reset values
// ----------------------------------------------------------------
`define PTC_Q_HI 2'h1
`define PTC_Q_LO 2'h2
`define PTC_PEND_RST 16'h0000
`define PTC_EVT_RST 16'h0000

`endif

// *** design/ptc_pkg.sv ***
`default_nettype none
package ptc_pkg;

  // Channel options word
  typedef struct packed {
    logic hi_pri;
    logic [1:0] element_size_field;
    logic src_two_dim;
    logic [1:0] source_update_mode;
    logic dst_two_dim;
    logic [1:0] dest_update_mode;
    logic completion_interrupt_enable;
    logic [3:0] report_code;
    logic frame_sync_select;
    logic link_enable;
  } ptc_opt_t;

  // One parameter set of the channel_setting_store
  typedef struct packed {
    ptc_opt_t opt;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] elem_cnt;
    logic [15:0] frame_cnt;
    logic [15:0] elem_idx;
    logic [15:0] frame_idx;
    logic [15:0] elem_reload;
    logic [5:0] link_addr;
  } ptc_set_t;

  // Transfer request toward the address generation logic
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [1:0] element_size_field;
    logic [1:0] queue;
    logic [3:0] channel;
  } ptc_req_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'b000_0001,
    S_RD = 7'b000_0010,
    S_LOAD = 7'b000_0100,
    S_XFER = 7'b000_1000,
    S_WB = 7'b001_0000,
    S_LRD = 7'b010_0000,
    S_LLD = 7'b100_0000
  } ptc_state_t;

  // Whole state of the channel service core
  typedef struct packed {
    ptc_state_t st;
    logic [3:0] ch;
    ptc_set_t set;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] sync3;
    logic [15:0] evt;
    logic [15:0] pend;
    ptc_req_t req;
    logic req_valid;
    logic irq;
    logic [3:0] irq_code;
    logic busy;
  } ptc_core_t;

endpackage : ptc_pkg
`default_nettype wire

// *** design/ptc_set_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ptc_map.svh"

// Parameter set storage, one write port and one registered read port
module ptc_set_mem (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Write port
  input wire logic we_in,
  input wire logic [5:0] waddr_in,
  input var ptc_pkg::ptc_set_t wdata_in,
  // Read port
  input wire logic [5:0] raddr_in,
  output ptc_pkg::ptc_set_t rdata_out
);

  ptc_pkg::ptc_set_t mem_q [`PTC_SET_DEPTH];

  // Storage is not reset; software loads every set it uses
  always_ff @(posedge clock_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // Read data comes out of a register, one cycle after the address
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem_q[raddr_in];
    end
  end

endmodule : ptc_set_mem

`default_nettype wire

// *** design/ptc_addr_step.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ptc_map.svh"

// Next address after one element, for one side of the channel
module ptc_addr_step (
  // Current address and mode
  input wire logic [31:0] addr_in,
  input wire logic [1:0] mode_in,
  input wire logic [1:0] shift_in,
  input wire logic two_dim_in,
  input wire logic last_in,
  // Indices and reload count
  input wire logic [15:0] elem_idx_in,
  input wire logic [15:0] frame_idx_in,
  input wire logic [15:0] reload_in,
  // Result
  output logic [31:0] addr_out
);

  logic [31:0] step;
  logic [31:0] back;
  logic [31:0] eidx;
  logic [31:0] fidx;

  // Byte step, distance back to array start, sign-extended indices
  always_comb begin
    step = 32'h0000_0001 << shift_in;
    back = {16'h0000, reload_in - 16'h0001} << shift_in;
    eidx = {{16{elem_idx_in[15]}}, elem_idx_in};
    fidx = {{16{frame_idx_in[15]}}, frame_idx_in};
  end

  // Array index is the distance between array starts, so a 2-D side
  // rewinds to the array start before adding it
  always_comb begin
    unique case (mode_in)
      `PTC_UPD_HOLD: addr_out = addr_in; // RULE_04
      `PTC_UPD_INC: begin
        if (last_in && two_dim_in) begin
          addr_out = addr_in - back + fidx; // RULE_10
        end else begin
          addr_out = addr_in + step; // RULE_05
        end
      end
      `PTC_UPD_DEC: begin
        if (last_in && two_dim_in) begin
          addr_out = addr_in + back + fidx;
        end else begin
          addr_out = addr_in - step;
        end
      end
      `PTC_UPD_IDX: begin
        addr_out = last_in ? addr_in + fidx : addr_in + eidx; // RULE_06
      end
    endcase
  end

endmodule : ptc_addr_step

`default_nettype wire

// *** dv/ptc_chan_service_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checks of the channel service core
// ----------------------------------------------------------------
module ptc_chan_service_asserts (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Inputs watched
  input wire logic tr_ready_in,
  input wire logic [15:0] pend_clr_in,
  // Outputs watched
  input wire logic tr_valid_out,
  input var ptc_pkg::ptc_req_t tr_out,
  input wire logic cfg_busy_out,
  input wire logic [15:0] channel_pending_register_out,
  input wire logic completion_irq_out,
  input wire logic [3:0] completion_code_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_req_held: assert property (
    tr_valid_out && !tr_ready_in |=> tr_valid_out && $stable(tr_out))
    else $error("Request changed before it was accepted");
  a_queue_code: assert property (
    tr_valid_out |-> tr_out.queue == 2'h1 || tr_out.queue == 2'h2)
    else $error("Request on an unknown queue");
  a_first_issue: assert property (
    $rose(cfg_busy_out) |-> ##3 tr_valid_out)
    else $error("First request not issued three cycles after pick");
  a_valid_busy: assert property (
    tr_valid_out |-> cfg_busy_out)
    else $error("Request issued while idle");
  a_irq_pulse: assert property (
    completion_irq_out |=> !completion_irq_out)
    else $error("Completion interrupt longer than one cycle");
  a_irq_pend: assert property (
    completion_irq_out |-> channel_pending_register_out[completion_code_out])
    else $error("Interrupt without its pending bit");
  a_pend_sticky: assert property (
    ($past(channel_pending_register_out) & ~channel_pending_register_out
      & ~$past(pend_clr_in)) == 16'h0000)
    else $error("Pending bit fell without a clear");
  a_pend_clears: assert property (
    pend_clr_in != 16'h0000 |=> completion_irq_out ||
      (channel_pending_register_out & $past(pend_clr_in)) == 16'h0000)
    else $error("Pending bit survived its clear");
  a_code_holds: assert property (
    !completion_irq_out |-> $stable(completion_code_out))
    else $error("Report code moved without an interrupt");
endmodule : ptc_chan_service_asserts

bind ptc_chan_service ptc_chan_service_asserts i_ptc_chan_service_asserts (
  .clock_in(clock_in),
  .rst_in(rst_in),
  .tr_ready_in(tr_ready_in),
  .pend_clr_in(pend_clr_in),
  .tr_valid_out(tr_valid_out),
  .tr_out(tr_out),
  .cfg_busy_out(cfg_busy_out),
  .channel_pending_register_out(channel_pending_register_out),
  .completion_irq_out(completion_irq_out),
  .completion_code_out(completion_code_out)
);
`default_nettype wire

// *** dv/ptc_sport_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Serial port and external peripheral event pins
// ----------------------------------------------------------------
module ptc_sport_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // One request per element moved
  input wire logic [2:0] raise_in,
  // Pins: 0 transmit, 1 receive, 2 external line
  output logic [2:0] evt_out
);
  logic [2:0][2:0] hold_q;
  // Four clocks wide so the pin survives the core's synchronizers
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < 3; i++) begin
      if (rst_in)
        hold_q[i] <= 3'h0;
      else if (raise_in[i])
        hold_q[i] <= 3'h4;
      else if (hold_q[i] != 3'h0)
        hold_q[i] <= hold_q[i] - 3'h1;
    end
  end
  // One rising edge per element, idle low between
  always_comb begin
    for (int i = 0; i < 3; i++)
      evt_out[i] = (hold_q[i] != 3'h0);
  end
endmodule : ptc_sport_model
`default_nettype wire

// *** dv/ptc_chan_service_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ptc_chan_service_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] raise = 3'h0;
  logic [2:0] pins;
  logic [15:0] evt_en = 16'h0000;
  logic [15:0] cpu_set = 16'h0000;
  logic [15:0] pend_clr = 16'h0000;
  logic cfg_wr = 1'b0;
  logic [5:0] cfg_addr = 6'h00;
  ptc_pkg::ptc_set_t cfg_data = '0;
  logic tr_ready = 1'b1;
  logic cfg_busy, irq, tr_valid;
  logic [15:0] pend;
  logic [3:0] code;
  ptc_pkg::ptc_req_t tr;
  int bad_count = 0;
  int comparisons = 0;
  int irq_n = 0;

  ptc_chan_service i_ptc_chan_service (
    .clock_in(clock_in), .rst_in(rst_in),
    .transmit_event_zero_in(pins[0]), .receive_event_zero_in(pins[1]),
    .transmit_event_one_in(1'b0), .receive_event_one_in(1'b0),
    .external_irq_four_in(pins[2]), .other_evt_in(16'h0000),
    .event_enable_register_in(evt_en), .cpu_evt_set_in(cpu_set),
    .cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_addr), .cfg_data_in(cfg_data),
    .cfg_busy_out(cfg_busy), .pend_clr_in(pend_clr),
    .channel_pending_register_out(pend), .completion_irq_out(irq),
    .completion_code_out(code), .tr_valid_out(tr_valid), .tr_out(tr),
    .tr_ready_in(tr_ready));
  ptc_sport_model i_ptc_sport_model (.clock_in(clock_in),
    .rst_in(rst_in), .raise_in(raise), .evt_out(pins));

  // Clock and interrupt pulse counter, old value read at the edge
  initial forever #4 clock_in = ~clock_in;
  always @(posedge clock_in) if (irq === 1'b1) irq_n <= irq_n + 1;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cfg(input logic [5:0] a, input ptc_pkg::ptc_set_t s);
    @(posedge clock_in);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_data <= s;
    @(posedge clock_in);
    cfg_wr <= 1'b0;
  endtask : cfg
  task automatic fire(input int i);
    @(posedge clock_in);
    raise[i] <= 1'b1;
    @(posedge clock_in);
    raise[i] <= 1'b0;
  endtask : fire
  // Sampled mid-cycle; a held request is seen again until accepted
  task automatic get_req(output ptc_pkg::ptc_req_t r);
    int n;
    n = 0;
    @(negedge clock_in);
    while (tr_valid !== 1'b1 && n < 60) begin
      @(negedge clock_in);
      n++;
    end
    chk(n < 60, 1, "request wait");
    r = tr;
  endtask : get_req
  task automatic clear_pend(input logic [15:0] m);
    @(posedge clock_in);
    pend_clr <= m;
    @(posedge clock_in);
    pend_clr <= 16'h0000;
    repeat (2) @(posedge clock_in);
    chk(pend, 16'h0000, "pending cleared");
  endtask : clear_pend

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_rx();
    ptc_pkg::ptc_set_t s;
    ptc_pkg::ptc_req_t r;
    s = '0;
    s.opt.hi_pri = 1'b1;
    s.opt.element_size_field = 2'b10;
    s.opt.dest_update_mode = 2'b01;
    s.opt.completion_interrupt_enable = 1'b1;
    s.opt.report_code = 4'hD;
    s.src = 32'h0000_1000;
    s.dst = 32'h0000_8000;
    s.elem_cnt = 16'h0003;
    s.elem_reload = 16'h0003;
    cfg(6'h0D, s);
    evt_en <= 16'h3010;
    for (int k = 0; k < 3; k++) begin
      chk(pend[13], 1'b0, "pending early");
      fire(1);
      get_req(r);
      chk(r.src, 32'h0000_1000, "rx src");
      chk(r.dst, 32'h0000_8000 + k, "rx dst");
      chk(r.element_size_field, 2'b10, "rx size");
      chk(r.queue, 2'h1, "rx queue");
      chk(r.channel, 4'hD, "rx channel");
    end
    repeat (4) @(posedge clock_in);
    chk(pend, 16'h2000, "rx pending");
    chk(irq_n, 1, "rx irq count");
    chk(code, 4'hD, "rx code");
    clear_pend(16'h2000);
    $display("test rx element sync done");
  endtask : t_rx

  // Ping set 12, pong set 40, ping copy 41; next event fired at once
  task automatic t_tx_link();
    ptc_pkg::ptc_set_t s;
    ptc_pkg::ptc_req_t r;
    s = '0;
    s.opt.source_update_mode = 2'b11;
    s.opt.completion_interrupt_enable = 1'b1;
    s.opt.report_code = 4'hC;
    s.opt.link_enable = 1'b1;
    s.dst = 32'h0000_7000;
    s.elem_cnt = 16'h0002;
    s.frame_cnt = 16'h0001;
    s.elem_reload = 16'h0002;
    s.elem_idx = 16'h0004;
    s.frame_idx = 16'h0100;
    for (int j = 0; j < 3; j++) begin
      s.src = (j == 1) ? 32'h0000_3000 : 32'h0000_2000;
      s.link_addr = (j == 1) ? 6'h29 : 6'h28;
      cfg((j == 0) ? 6'h0C : 6'(6'h27 + j), s);
    end
    for (int k = 0; k < 9; k++) begin
      fire(0);
      get_req(r);
      chk(r.src, (((k / 4) % 2 == 1) ? 32'h0000_3000 : 32'h0000_2000)
        + (k % 2) * 4 + ((k / 2) % 2) * 32'h0000_0104, "tx src");
      chk(r.dst, 32'h0000_7000, "tx dst");
      chk(r.queue, 2'h2, "tx queue");
      chk(r.channel, 4'hC, "tx channel");
    end
    repeat (10) @(posedge clock_in);
    chk(irq_n, 3, "tx irq count");
    chk(pend, 16'h1000, "tx pending");
    clear_pend(16'h1000);
    $display("test tx link ping-pong done");
  endtask : t_tx_link

  // One pin event and one CPU trigger, each moving a whole array
  task automatic t_ext4();
    ptc_pkg::ptc_set_t s;
    ptc_pkg::ptc_req_t r;
    s = '0;
    s.opt.hi_pri = 1'b1;
    s.opt.element_size_field = 2'b01;
    s.opt.dest_update_mode = 2'b01;
    s.opt.dst_two_dim = 1'b1;
    s.opt.frame_sync_select = 1'b1;
    s.src = 32'h0000_5000;
    s.dst = 32'h0001_0000;
    s.elem_cnt = 16'h0003;
    s.frame_cnt = 16'h0001;
    s.elem_reload = 16'h0003;
    s.frame_idx = 16'h0040;
    cfg(6'h04, s);
    tr_ready <= 1'b0;
    fire(2);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) begin
        @(posedge clock_in);
        cpu_set <= 16'h0010;
        @(posedge clock_in);
        cpu_set <= 16'h0000;
      end
      get_req(r);
      chk(r.dst, 32'h0001_0000 + (k / 3) * 32'h0000_0040 + (k % 3) * 2,
        "ext dst");
      chk(r.channel, 4'h4, "ext channel");
      if (k == 0) begin
        repeat (3) @(posedge clock_in);
        chk(tr_valid, 1'b1, "stalled valid");
        chk(cfg_busy, 1'b1, "busy while stalled");
        tr_ready <= 1'b1;
        @(posedge clock_in);
      end
    end
    repeat (20) @(posedge clock_in);
    chk(tr_valid, 1'b0, "no extra request");
    chk(cfg_busy, 1'b0, "idle after block");
    chk(pend, 16'h0000, "ext pending");
    chk(irq_n, 3, "ext irq count");
    $display("test ext array sync done");
  endtask : t_ext4

  // ----------------------------------------------------------------
  // Verdict, sequence and watchdog
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    t_rx();
    t_tx_link();
    t_ext4();
    summarize();
  end
  // About 200 cycles expected; 150 times that before giving up
  initial begin
    #240_000;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : ptc_chan_service_tb
`default_nettype wire
